// *** logic/pinsel_pkg.sv ***
// Constants and types shared by the port A pin-function selector.
package pinsel_pkg;

    // Port geometry.
    localparam int PORT_WIDTH = 16;
    localparam int DEC_WIDTH = 8;

    // Register byte offsets within the slave's window, all word aligned.
    localparam logic [7:0] REG_FUNC_OFS = 8'h00;
    localparam logic [7:0] REG_DIR_OFS = 8'h04;
    localparam logic [7:0] REG_ROUTE_OFS = 8'h08;

    // Reset values of the software registers.
    localparam logic [15:0] FUNC_RESET = 16'h0000;
    localparam logic [15:0] DIR_RESET = 16'h0000;

    // Bus encodings used by the slave.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic HRESP_OKAY = 1'h0;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // Chip operating mode as strapped by the mode pins.
    typedef enum logic [1:0] {
        MODE_SINGLE_CHIP,
        MODE_EXP_ROM_ON,
        MODE_EXP_ROM_OFF
    } op_mode_t;

endpackage : pinsel_pkg

// *** logic/pin_route_if.sv ***
// Interface carrying per-pin routing selects and pad values between selector and pad driver.
`timescale 1ns/1ps
interface pin_route_if #(
    parameter int WIDTH = 16
);
    logic [WIDTH-1:0] addr_sel;
    logic [WIDTH-1:0] dir;
    logic [WIDTH-1:0] addr_val;
    logic [WIDTH-1:0] gpio_val;
    logic [WIDTH-1:0] pad_val;
    logic [WIDTH-1:0] pad_en;

    // The selector decides routing; the pad driver turns it into pin levels.
    modport ctrl (
        output addr_sel,
        output dir,
        output addr_val,
        output gpio_val,
        input pad_val,
        input pad_en
    );
    modport route (
        input addr_sel,
        input dir,
        input addr_val,
        input gpio_val,
        output pad_val,
        output pad_en
    );
endinterface : pin_route_if

// *** logic/pin_route.sv ***
// Registered pad driver that applies the per-pin routing choice to every port pin.
`timescale 1ns/1ps
module pin_route #(
    parameter int WIDTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    pin_route_if.route rt
);
    import pinsel_pkg::*;

    logic [WIDTH-1:0] pad_val_q;
    logic [WIDTH-1:0] pad_en_q;
    logic [WIDTH-1:0] pad_val_d;
    logic [WIDTH-1:0] pad_en_d;

    // Each pin picks its own source, so the selection is one generate per bit.
    for (genvar n = 0; n < WIDTH; n++)
    begin : g_pin
        always_comb
        begin
            pad_val_d[n] = rt.addr_sel[n] ? rt.addr_val[n] : rt.gpio_val[n];
            pad_en_d[n] = rt.addr_sel[n] | rt.dir[n];
        end

        // A pin chosen for address must mirror only its own address line.
        pin_owns_bit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
            rt.addr_sel[n] |=> pad_en_q[n] && pad_val_q[n] == $past(rt.addr_val[n]))
            else $error("Address-routed pin does not follow its own address line.");
    end

    // Pads are registered so the pin never glitches while the mode or selects settle.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            pad_val_q <= '0;
            pad_en_q <= '0;
        end
        else
        begin
            pad_val_q <= pad_val_d;
            pad_en_q <= pad_en_d;
        end
    end

    assign rt.pad_val = pad_val_q;
    assign rt.pad_en = pad_en_q;

endmodule : pin_route

// *** logic/port_a_pin_select.sv ***
// Port A pin-function selector with an AHB-Lite register slave.
// Operation
// - A 16-bit read/write function-control register holds one mode bit for each of the 16 pins.
// - Mode bit n affects only pin n.
// - In expanded mode with ROM off every pin drives its address line and the bits are ignored.
// - In expanded mode with ROM on a bit of 0 gives general I/O and a bit of 1 the address line.
// - In single-chip mode every pin is general I/O whatever the mode bits hold.
// - The register clears to zero on power-on reset and while hardware standby is held.
// - Software standby, sleep and watchdog reset leave the register untouched.
// - A general I/O pin is an output when its direction bit is 1 and an input when 0.
//
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module port_a_pin_select #(
    parameter int WIDTH = 16
) (
    input wire logic MCLK_I,
    input wire logic RESET_N_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire pinsel_pkg::op_mode_t MODE_I,
    input wire logic HW_STANDBY_I,
    input wire logic [WIDTH-1:0] ADDR_LINE_I,
    input wire logic [WIDTH-1:0] GPIO_DATA_I,
    input wire logic [WIDTH-1:0] PA_I,
    output logic [WIDTH-1:0] PA_O,
    output logic [WIDTH-1:0] PA_OE_O,
    output logic [WIDTH-1:0] GPIO_LEVEL_O
);
    import pinsel_pkg::*;

    // The register map holds one mode bit per pin in a 16-bit field.
    if (WIDTH != PORT_WIDTH)
    begin : g_width_check
        $error("WIDTH must equal the 16 pins of port A.");
    end

    logic acc_valid_q;
    logic acc_write_q;
    logic [DEC_WIDTH-1:0] acc_addr_q;
    logic [WIDTH-1:0] func_q;
    logic [WIDTH-1:0] dir_q;
    logic [31:0] rdata_q;
    logic [WIDTH-1:0] level_q;
    logic [WIDTH-1:0] addr_sel;
    logic addr_take;
    logic wr_func;
    logic wr_dir;
    logic [31:0] rdata_d;
    logic [DEC_WIDTH-1:0] rd_addr;

    pin_route_if #(.WIDTH(WIDTH)) route_bus ();

    // The slave never inserts wait states and never errors.
    assign HREADYOUT_O = 1'h1;
    assign HRESP_O = HRESP_OKAY;
    assign addr_take = HSEL_I && HREADY_I && (HTRANS_I == HTRANS_NONSEQ || HTRANS_I == HTRANS_SEQ);
    assign rd_addr = HADDR_I[DEC_WIDTH-1:0];

    // Address phase is captured so the write lands in the data phase.
    always_ff @(posedge MCLK_I)
    begin
        if (!RESET_N_I)
        begin
            acc_valid_q <= 1'h0;
            acc_write_q <= 1'h0;
            acc_addr_q <= '0;
        end
        else if (HREADY_I)
        begin
            acc_valid_q <= addr_take;
            acc_write_q <= HWRITE_I;
            acc_addr_q <= rd_addr;
        end
    end

    assign wr_func = acc_valid_q && acc_write_q && acc_addr_q == REG_FUNC_OFS;
    assign wr_dir = acc_valid_q && acc_write_q && acc_addr_q == REG_DIR_OFS;

    // Only power-on reset and hardware standby clear the mode bits; nothing else can.
    always_ff @(posedge MCLK_I)
    begin
        if (!RESET_N_I || HW_STANDBY_I)
        begin
            func_q <= FUNC_RESET;
        end
        else if (wr_func)
        begin
            func_q <= HWDATA_I[WIDTH-1:0];
        end
    end

    // Direction bits share the same clearing conditions as the mode bits.
    always_ff @(posedge MCLK_I)
    begin
        if (!RESET_N_I || HW_STANDBY_I)
        begin
            dir_q <= DIR_RESET;
        end
        else if (wr_dir)
        begin
            dir_q <= HWDATA_I[WIDTH-1:0];
        end
    end

    // The operating mode decides whether the mode bits matter at all.
    always_comb
    begin
        unique case (MODE_I)
            MODE_EXP_ROM_OFF: addr_sel = '1;
            MODE_EXP_ROM_ON: addr_sel = func_q;
            MODE_SINGLE_CHIP: addr_sel = '0;
            default: addr_sel = '0;
        endcase
    end

    // Read data is prepared in the address phase; a write still in its data phase
    // to the same word is forwarded so back-to-back write and read agree.
    always_comb
    begin
        rdata_d = RDATA_ZERO;
        if (rd_addr == REG_FUNC_OFS)
        begin
            rdata_d[WIDTH-1:0] = wr_func ? HWDATA_I[WIDTH-1:0] : func_q;
        end
        else if (rd_addr == REG_DIR_OFS)
        begin
            rdata_d[WIDTH-1:0] = wr_dir ? HWDATA_I[WIDTH-1:0] : dir_q;
        end
        else if (rd_addr == REG_ROUTE_OFS)
        begin
            rdata_d[WIDTH-1:0] = addr_sel;
        end
        if (HW_STANDBY_I)
        begin
            rdata_d = RDATA_ZERO;
        end
    end

    always_ff @(posedge MCLK_I)
    begin
        if (!RESET_N_I)
        begin
            rdata_q <= RDATA_ZERO;
        end
        else if (addr_take && !HWRITE_I)
        begin
            rdata_q <= rdata_d;
        end
    end

    // Pin levels are sampled once so the port data logic sees a clean value.
    always_ff @(posedge MCLK_I)
    begin
        if (!RESET_N_I)
        begin
            level_q <= '0;
        end
        else
        begin
            level_q <= PA_I;
        end
    end

    assign route_bus.addr_sel = addr_sel;
    assign route_bus.dir = dir_q;
    assign route_bus.addr_val = ADDR_LINE_I;
    assign route_bus.gpio_val = GPIO_DATA_I;

    pin_route #(.WIDTH(WIDTH)) u_route (
        .clk_i(MCLK_I),
        .rst_n_i(RESET_N_I),
        .rt(route_bus.route)
    );

    assign PA_O = route_bus.pad_val;
    assign PA_OE_O = route_bus.pad_en;
    assign HRDATA_O = rdata_q;
    assign GPIO_LEVEL_O = level_q;

    // A write to the mode word, an idle address phase and then a read return the written bits.
    sequence func_write_s;
        addr_take && HWRITE_I && rd_addr == REG_FUNC_OFS;
    endsequence
    sequence func_read_s;
        addr_take && !HWRITE_I && rd_addr == REG_FUNC_OFS && !HW_STANDBY_I;
    endsequence

    ctrl_readback_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
        func_write_s ##1 (!addr_take && !HW_STANDBY_I) ##1 func_read_s
        |=> HRDATA_O == {16'h0000, $past(HWDATA_I[WIDTH-1:0], 2)})
        else $error("Mode word did not read back as written.");

    rom_off_addr_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
        MODE_I == MODE_EXP_ROM_OFF |=> PA_OE_O == '1 && PA_O == $past(ADDR_LINE_I))
        else $error("Address pins not driven in expanded mode with ROM off.");

    rom_on_mix_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
        MODE_I == MODE_EXP_ROM_ON |=> PA_O == (($past(func_q) & $past(ADDR_LINE_I))
        | (~$past(func_q) & $past(GPIO_DATA_I))))
        else $error("Mode bits not applied in expanded mode with ROM on.");

    single_chip_io_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
        MODE_I == MODE_SINGLE_CHIP |=> PA_OE_O == $past(dir_q) && PA_O == $past(GPIO_DATA_I))
        else $error("Single-chip pin not on general I/O.");

    standby_clear_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
        HW_STANDBY_I |=> func_q == FUNC_RESET && dir_q == DIR_RESET)
        else $error("Hardware standby did not clear the mode word.");

    // Read data only changes when a read is taken, so the zero is checked there.
    standby_read_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
        HW_STANDBY_I && addr_take && !HWRITE_I |=> HRDATA_O == RDATA_ZERO)
        else $error("Read in hardware standby did not return zero.");

    bits_retained_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
        !wr_func && !HW_STANDBY_I |=> $stable(func_q))
        else $error("Mode word changed without a write or clear.");

    gpio_direction_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
        MODE_I != MODE_EXP_ROM_OFF |=> (PA_OE_O & ~$past(addr_sel)) == ($past(dir_q)
        & ~$past(addr_sel)))
        else $error("General I/O pin direction does not follow its direction bit.");

    read_any_mode_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
        (func_read_s and !wr_func) |=> HRDATA_O[WIDTH-1:0] == $past(func_q))
        else $error("Mode word read differs from stored value.");

endmodule : port_a_pin_select

// *** test/pin_partner.sv ***
// Model of the outside world on the port A pins.
`timescale 1ns/1ps
module pin_partner #(
    parameter int WIDTH = 16
) (
    input wire logic [WIDTH-1:0] pa_o_i,
    input wire logic [WIDTH-1:0] pa_oe_i,
    input wire logic [WIDTH-1:0] ext_i,
    output logic [WIDTH-1:0] pin_o
);
    // A pin the device drives shows its level; any other shows the external driver.
    assign pin_o = (pa_oe_i & pa_o_i) | (~pa_oe_i & ext_i);
endmodule : pin_partner

// *** test/test_port_a_pin_select.sv ***
// Self-checking bench for the port A pin-function selector.
`timescale 1ns/1ps
module test_port_a_pin_select;
    import pinsel_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic standby = 1'b0;
    op_mode_t mode = MODE_SINGLE_CHIP;
    logic [15:0] addr_line = 16'h0;
    logic [15:0] gpio = 16'h0;
    logic [15:0] ext = 16'h0;
    wire logic [31:0] hrdata;
    wire logic hready;
    wire logic hresp;
    wire logic [15:0] pa_o;
    wire logic [15:0] pa_oe;
    wire logic [15:0] pin;
    wire logic [15:0] level;
    int fails = 0;
    int n_compared = 0;
    int seed = 94;
    int cycles = 0;
    logic [31:0] rd;
    logic [15:0] f;
    logic [15:0] d;
    logic [47:0] e;

    port_a_pin_select u_dut (.MCLK_I(mclk), .RESET_N_I(reset_n), .HSEL_I(1'b1),
        .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
        .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
        .HRESP_O(hresp), .MODE_I(mode), .HW_STANDBY_I(standby), .ADDR_LINE_I(addr_line),
        .GPIO_DATA_I(gpio), .PA_I(pin), .PA_O(pa_o), .PA_OE_O(pa_oe), .GPIO_LEVEL_O(level));
    pin_partner u_far (.pa_o_i(pa_o), .pa_oe_i(pa_oe), .ext_i(ext), .pin_o(pin));

    // Free-running 200 MHz clock.
    initial
    begin
        forever #2.5 mclk = ~mclk;
    end

    // Cuts a hang short; the tests take well under a thousand cycles.
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            test_done();
        end
    end

    // Expected route, output enable and driven output value for one setting: {sel, oe, out}.
    function automatic logic [47:0] expect_pins(input op_mode_t m, input logic [15:0] fc,
        input logic [15:0] dc, input logic [15:0] a, input logic [15:0] g);
        logic [15:0] sel;
        sel = (m == MODE_EXP_ROM_OFF) ? 16'hFFFF : (m == MODE_EXP_ROM_ON) ? fc : 16'h0000;
        return {sel, sel | dc, (sel & a) | (~sel & g)};
    endfunction : expect_pins

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask : check

    // One single AHB-Lite transfer; entered and left just after a rising edge.
    task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
        output logic [31:0] rdv);
        haddr <= {24'h0, ofs};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hready !== 1'b1);
        rdv = hrdata;
    endtask : bus

    task test_done;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // Main sequence: reset, walking ones, random settings, standby, unmapped space.
    initial
    begin
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        check("oe after reset", {16'h0, pa_oe}, 32'h0);
        bus(1'b0, REG_FUNC_OFS, 32'h0, rd);
        check("function after reset", rd, {16'h0, FUNC_RESET});
        $display("test reset done");
        for (int i = 0; i < 48; i++)
        begin
            f = (i < 16) ? (16'h0001 << i) : 16'($random(seed));
            d = 16'($random(seed));
            mode <= (i < 16) ? MODE_EXP_ROM_ON : op_mode_t'(2'($unsigned($random(seed)) % 3));
            addr_line <= 16'($random(seed));
            gpio <= 16'($random(seed));
            ext <= 16'($random(seed));
            bus(1'b1, REG_FUNC_OFS, {16'h0, f}, rd);
            bus(1'b1, REG_DIR_OFS, {16'h0, d}, rd);
            bus(1'b0, REG_FUNC_OFS, 32'h0, rd);
            check("function read", rd, {16'h0, f});
            check("response", {31'h0, hresp}, {31'h0, HRESP_OKAY});
            bus(1'b0, REG_ROUTE_OFS, 32'h0, rd);
            repeat (2) @(posedge mclk);
            #1;
            e = expect_pins(mode, f, d, addr_line, gpio);
            check("route status", rd, {16'h0, e[47:32]});
            check("pins", {pa_oe, pa_o}, e[31:0]);
            check("level", {16'h0, level}, {16'h0, (e[31:16] & e[15:0]) | (~e[31:16] & ext)});
            @(posedge mclk);
        end
        $display("test routing done");
        bus(1'b1, REG_FUNC_OFS, 32'h0000_A5A5, rd);
        bus(1'b0, REG_FUNC_OFS, 32'h0, rd);
        check("function written", rd, 32'h0000_A5A5);
        repeat (20) @(posedge mclk);
        bus(1'b0, REG_FUNC_OFS, 32'h0, rd);
        check("function kept", rd, 32'h0000_A5A5);
        standby <= 1'b1;
        bus(1'b0, REG_FUNC_OFS, 32'h0, rd);
        check("read in standby", rd, RDATA_ZERO);
        standby <= 1'b0;
        @(posedge mclk);
        bus(1'b0, REG_FUNC_OFS, 32'h0, rd);
        check("function after standby", rd, {16'h0, FUNC_RESET});
        bus(1'b0, REG_DIR_OFS, 32'h0, rd);
        check("direction after standby", rd, {16'h0, DIR_RESET});
        $display("test standby done");
        bus(1'b1, 8'h0C, 32'h0000_FFFF, rd);
        bus(1'b0, 8'h0C, 32'h0, rd);
        check("unmapped read", rd, RDATA_ZERO);
        bus(1'b0, REG_FUNC_OFS, 32'h0, rd);
        check("function untouched", rd, {16'h0, FUNC_RESET});
        $display("test unmapped done");
        test_done();
    end
endmodule : test_port_a_pin_select
